// ### src/clid_pkg.sv
// Constants, field layout and types of the character display instruction decoder
package clid_pkg;

  // Clock and execution times
  localparam int unsigned CLK_PERIOD_NS = 10;      // 100 MHz system clock
  localparam int unsigned T_LONG_NS     = 1530000; // Clear and home, 1.53 ms
  localparam int unsigned T_SHORT_NS    = 39000;   // Most instructions, 39 us
  localparam int unsigned T_DATA_NS     = 43000;   // Data read or write, 43 us
  // All times round down to whole cycles
  localparam int unsigned CYC_LONG  = T_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_SHORT = T_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_DATA  = T_DATA_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W     = 18;

  // Memory sizes
  localparam int unsigned TEXT_DEPTH  = 128;
  localparam int unsigned GLYPH_DEPTH = 64;
  localparam int unsigned ADDR_W      = 7;

  // Instruction classes by position of the leading one
  localparam int unsigned OP_TEXT_ADDR  = 7;
  localparam int unsigned OP_GLYPH_ADDR = 6;
  localparam int unsigned OP_FUNCTION   = 5;
  localparam int unsigned OP_SHIFT      = 4;
  localparam int unsigned OP_DISPLAY    = 3;
  localparam int unsigned OP_ENTRY      = 2;
  localparam int unsigned OP_HOME       = 1;
  localparam int unsigned OP_CLEAR      = 0;

  // Field positions inside the instruction and status bytes
  localparam int unsigned ENTRY_INC_BIT = 1;
  localparam int unsigned ENTRY_SCR_BIT = 0;
  localparam int unsigned DISP_ON_BIT   = 2;
  localparam int unsigned CUR_ON_BIT    = 1;
  localparam int unsigned BLINK_BIT     = 0;
  localparam int unsigned SHIFT_SC_BIT  = 3;
  localparam int unsigned SHIFT_RL_BIT  = 2;
  localparam int unsigned FN_BW_BIT     = 4;
  localparam int unsigned FN_N_BIT      = 3;
  localparam int unsigned FN_F_BIT      = 2;
  localparam int unsigned BUSY_BIT      = 7;

  // Values after reset and fixed codes
  localparam logic       RST_BUS8      = 1'b1;
  localparam logic       RST_TWO_LINE  = 1'b0;
  localparam logic       RST_TALL      = 1'b0;
  localparam logic       RST_DISP_ON   = 1'b0;
  localparam logic       RST_CUR_ON    = 1'b0;
  localparam logic       RST_BLINK     = 1'b0;
  localparam logic       RST_INC       = 1'b1;
  localparam logic       RST_SCROLL    = 1'b0;
  localparam logic [7:0] SPACE_CODE    = 8'h20;
  localparam logic [6:0] HOME_ADDR     = 7'h00;
  localparam logic [6:0] RST_SHIFT     = 7'h00;

  // Execution engine states
  typedef enum logic [1:0] {
    CL_IDLE = 2'b00,
    CL_BUSY = 2'b01,
    CL_FILL = 2'b10
  } clid_state_e;

endpackage : clid_pkg

// ### src/clid_decoder.sv
// Instruction decoder and executor of the character display controller
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Latch host transfers, execute at internal rate
// - Busy flag reads high on line 7
// - Clear fills spaces, pointer zero, 1.53 ms
// - Clear also sets incrementing entry direction
// - Home zeroes pointer and shift, keeps text
// - Entry mode stores direction and shift, 39us
// - Direction high steps address up after access
// - Direction low steps address down after access
// - Glyph accesses step address like text accesses
// - No display shift on reads or glyphs
// - Shift option scrolls display on text writes
// - Display control stores enable, cursor, blink
// - Shift command moves cursor or display, 39us
// - Function set stores width, lines, font
// - Glyph address loads pointer, selects glyph memory
// - Text address loads pointer, selects text memory
// - Status read returns busy and pointer anytime
// - Data write stores byte, steps pointer, 43us
// - Data read returns byte, steps pointer, 43us
// - Narrow bus moves bytes as two nibbles
// - Display disabled blanks output, keeps memory
module clid_decoder
  import clid_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = CYC_LONG,
  parameter int unsigned DATA_CYCLES = CYC_DATA
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         cmd_data_select_i,
  input  wire logic         read_not_write_i,
  input  wire logic         enable_strobe_i,
  input  wire logic [7:0]   bus_lines_i,
  output var  logic [7:0]   bus_lines_o,
  output var  logic         bus_lines_oe_o,
  input  wire logic [6:0]   scan_addr_i,
  output var  logic [7:0]   scan_char_o,
  output var  logic         internal_busy_flag_o,
  output var  logic [6:0]   address_pointer_o,
  output var  logic         display_on_o,
  output var  logic         cursor_on_o,
  output var  logic         cursor_blink_o,
  output var  logic         two_line_o,
  output var  logic         tall_font_o,
  output var  logic         bus_width_select_o,
  output var  logic         entry_increment_o,
  output var  logic         scroll_on_write_o,
  output var  logic [6:0]   display_shift_o
);

  localparam logic [CNT_W-1:0] LONG_CNT  = CNT_W'(LONG_CYCLES);
  localparam logic [CNT_W-1:0] SHORT_CNT = CNT_W'(CYC_SHORT);
  localparam logic [CNT_W-1:0] DATA_CNT  = CNT_W'(DATA_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // Step an address by one, wrapping inside the selected memory
  function automatic logic [6:0] clid_step(input logic [6:0] a,
                                           input logic       up,
                                           input logic       glyph);
    logic [6:0] n;
    n = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      n[6] = 1'b0;
    end
    return n;
  endfunction : clid_step

  // Pin synchronisers and strobe edge history
  logic        sel_s1_r;
  logic        sel_s2_r;
  logic        rw_s1_r;
  logic        rw_s2_r;
  logic        e_s1_r;
  logic        e_s2_r;
  logic        e_d_r;
  logic [7:0]  db_s1_r;
  logic [7:0]  db_s2_r;

  // Nibble assembly
  logic        nib_lo_r;
  logic [3:0]  hold_r;

  // Configuration
  logic        bus8_r;
  logic        two_line_r;
  logic        tall_r;
  logic        disp_on_r;
  logic        cur_on_r;
  logic        blink_r;
  logic        inc_r;
  logic        scroll_r;
  logic        sel_glyph_r;

  // Pointer, shift, engine
  logic [6:0]       ptr_r;
  logic [6:0]       shift_r;
  clid_state_e      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [6:0]       fill_idx_r;
  logic             busy_r;

  // Storage
  logic [7:0] text_mem_r  [TEXT_DEPTH];
  logic [7:0] glyph_mem_r [GLYPH_DEPTH];

  // Pin output registers
  logic [7:0] bus_out_r;
  logic       bus_oe_r;
  logic [7:0] scan_char_r;

  // Decoded strobes
  logic       e_rise;
  logic       e_fall;
  logic       xfer_done;
  logic       idle;
  logic [7:0] byte_in;
  logic       wr_cmd;
  logic       wr_data;
  logic       rd_data;
  logic [7:0] rd_byte;
  logic [7:0] cmd_onehot;

  // Two flip-flops on every pin before use
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
      rw_s1_r <= 1'b0;
      rw_s2_r <= 1'b0;
      e_s1_r  <= 1'b0;
      e_s2_r  <= 1'b0;
      e_d_r   <= 1'b0;
      db_s1_r <= 8'h00;
      db_s2_r <= 8'h00;
    end else begin
      sel_s1_r <= cmd_data_select_i;
      sel_s2_r <= sel_s1_r;
      rw_s1_r <= read_not_write_i;
      rw_s2_r <= rw_s1_r;
      e_s1_r  <= enable_strobe_i;
      e_s2_r  <= e_s1_r;
      e_d_r   <= e_s2_r;
      db_s1_r <= bus_lines_i;
      db_s2_r <= db_s1_r;
    end
  end

  // Strobe edges and byte completion
  assign e_rise    = e_s2_r & ~e_d_r;
  assign e_fall    = ~e_s2_r & e_d_r;
  assign xfer_done = e_fall & (bus8_r | nib_lo_r);
  assign byte_in   = bus8_r ? db_s2_r : {hold_r, db_s2_r[7:4]};
  assign idle      = (state_r == CL_IDLE);

  // Transfers latched only when idle
  assign wr_cmd  = xfer_done & ~rw_s2_r & ~sel_s2_r & idle;
  assign wr_data = xfer_done & ~rw_s2_r & sel_s2_r & idle;
  assign rd_data = xfer_done & rw_s2_r & sel_s2_r & idle;

  // Leading-one decode of the instruction byte
  always_comb begin
    cmd_onehot = 8'h00;
    casez (byte_in)
      8'b1???????: cmd_onehot[OP_TEXT_ADDR]  = 1'b1;
      8'b01??????: cmd_onehot[OP_GLYPH_ADDR] = 1'b1;
      8'b001?????: cmd_onehot[OP_FUNCTION]   = 1'b1;
      8'b0001????: cmd_onehot[OP_SHIFT]      = 1'b1;
      8'b00001???: cmd_onehot[OP_DISPLAY]    = 1'b1;
      8'b000001??: cmd_onehot[OP_ENTRY]      = 1'b1;
      8'b0000001?: cmd_onehot[OP_HOME]       = 1'b1;
      8'b00000001: cmd_onehot[OP_CLEAR]      = 1'b1;
      default:     cmd_onehot = 8'h00;
    endcase
  end

  // Nibble pairing, upper half first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nib_lo_r <= 1'b0;
      hold_r   <= 4'h0;
    end else if (bus8_r) begin
      nib_lo_r <= 1'b0;
    end else if (e_fall) begin
      nib_lo_r <= ~nib_lo_r;
      if (!nib_lo_r) begin
        hold_r <= db_s2_r[7:4];
      end
    end
  end

  // Configuration bits set by instructions
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus8_r      <= RST_BUS8;
      two_line_r  <= RST_TWO_LINE;
      tall_r      <= RST_TALL;
      disp_on_r   <= RST_DISP_ON;
      cur_on_r    <= RST_CUR_ON;
      blink_r     <= RST_BLINK;
      inc_r       <= RST_INC;
      scroll_r    <= RST_SCROLL;
      sel_glyph_r <= 1'b0;
    end else if (wr_cmd) begin
      if (cmd_onehot[OP_CLEAR]) begin
        inc_r <= 1'b1;
      end
      if (cmd_onehot[OP_ENTRY]) begin
        inc_r    <= byte_in[ENTRY_INC_BIT];
        scroll_r <= byte_in[ENTRY_SCR_BIT];
      end
      if (cmd_onehot[OP_DISPLAY]) begin
        disp_on_r <= byte_in[DISP_ON_BIT];
        cur_on_r  <= byte_in[CUR_ON_BIT];
        blink_r   <= byte_in[BLINK_BIT];
      end
      if (cmd_onehot[OP_FUNCTION]) begin
        bus8_r     <= byte_in[FN_BW_BIT];
        two_line_r <= byte_in[FN_N_BIT];
        tall_r     <= byte_in[FN_F_BIT];
      end
      if (cmd_onehot[OP_GLYPH_ADDR]) begin
        sel_glyph_r <= 1'b1;
      end
      if (cmd_onehot[OP_TEXT_ADDR] || cmd_onehot[OP_CLEAR] ||
          cmd_onehot[OP_HOME]) begin
        sel_glyph_r <= 1'b0;
      end
    end
  end

  // Address pointer loads and steps
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_r <= HOME_ADDR;
    end else if (wr_cmd) begin
      if (cmd_onehot[OP_CLEAR] || cmd_onehot[OP_HOME]) begin
        ptr_r <= HOME_ADDR;
      end else if (cmd_onehot[OP_GLYPH_ADDR]) begin
        ptr_r <= {1'b0, byte_in[5:0]};
      end else if (cmd_onehot[OP_TEXT_ADDR]) begin
        ptr_r <= byte_in[6:0];
      end else if (cmd_onehot[OP_SHIFT] && !byte_in[SHIFT_SC_BIT]) begin
        ptr_r <= clid_step(ptr_r, byte_in[SHIFT_RL_BIT], sel_glyph_r);
      end
    end else if (wr_data || rd_data) begin
      ptr_r <= clid_step(ptr_r, inc_r, sel_glyph_r);
    end
  end

  // Display shift offset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      shift_r <= RST_SHIFT;
    end else if (wr_cmd) begin
      if (cmd_onehot[OP_CLEAR] || cmd_onehot[OP_HOME]) begin
        shift_r <= RST_SHIFT;
      end else if (cmd_onehot[OP_SHIFT] && byte_in[SHIFT_SC_BIT]) begin
        shift_r <= byte_in[SHIFT_RL_BIT] ? shift_r - 7'h01
                                         : shift_r + 7'h01;
      end
    end else if (wr_data && scroll_r && !sel_glyph_r) begin
      shift_r <= inc_r ? shift_r + 7'h01 : shift_r - 7'h01;
    end
  end

  // Execution timer and busy state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= CL_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        CL_IDLE: begin
          if (wr_cmd) begin
            if (cmd_onehot[OP_CLEAR]) begin
              state_r <= CL_FILL;
              cnt_r   <= LONG_CNT;
            end else if (cmd_onehot[OP_HOME]) begin
              state_r <= CL_BUSY;
              cnt_r   <= LONG_CNT;
            end else if (cmd_onehot != 8'h00) begin
              state_r <= CL_BUSY;
              cnt_r   <= SHORT_CNT;
            end
          end else if (wr_data || rd_data) begin
            state_r <= CL_BUSY;
            cnt_r   <= DATA_CNT;
          end
        end
        CL_FILL: begin
          cnt_r <= cnt_r - CNT_ONE;
          if (fill_idx_r == 7'h7F) begin
            state_r <= (cnt_r <= CNT_ONE) ? CL_IDLE : CL_BUSY;
          end
        end
        CL_BUSY: begin
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r <= CNT_ONE) begin
            state_r <= CL_IDLE;
          end
        end
        default: begin
          state_r <= CL_IDLE;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // Busy flag register, follows the engine's next state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else if (idle) begin
      busy_r <= (wr_cmd && (cmd_onehot != 8'h00)) ||
                wr_data || rd_data;
    end else begin
      busy_r <= ((state_r == CL_BUSY || state_r == CL_FILL) &&
                 (cnt_r > CNT_ONE)) ||
                ((state_r == CL_FILL) && (fill_idx_r != 7'h7F));
    end
  end

  // Fill index walks text memory during clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fill_idx_r <= 7'h00;
    end else if (state_r == CL_FILL) begin
      fill_idx_r <= fill_idx_r + 7'h01;
    end else begin
      fill_idx_r <= 7'h00;
    end
  end

  // Text and glyph storage
  always_ff @(posedge clk_sys_i) begin
    if (state_r == CL_FILL) begin
      text_mem_r[fill_idx_r] <= SPACE_CODE;
    end else if (wr_data) begin
      if (sel_glyph_r) begin
        glyph_mem_r[ptr_r[5:0]] <= byte_in;
      end else begin
        text_mem_r[ptr_r] <= byte_in;
      end
    end
  end

  // Byte presented on a read: status or memory
  assign rd_byte = sel_s2_r
                 ? (sel_glyph_r ? glyph_mem_r[ptr_r[5:0]]
                                : text_mem_r[ptr_r])
                 : {~idle, ptr_r};

  // Read drive on the data lines while the strobe is high
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_out_r <= 8'h00;
      bus_oe_r  <= 1'b0;
    end else begin
      bus_oe_r <= e_s2_r & rw_s2_r;
      if (e_rise && rw_s2_r) begin
        if (bus8_r) begin
          bus_out_r <= rd_byte;
        end else if (!nib_lo_r) begin
          bus_out_r <= {rd_byte[7:4], 4'h0};
        end else begin
          bus_out_r <= {rd_byte[3:0], 4'h0};
        end
      end
    end
  end

  // Character fetch for the scan logic, blank when disabled
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scan_char_r <= SPACE_CODE;
    end else if (disp_on_r) begin
      scan_char_r <= text_mem_r[scan_addr_i + shift_r];
    end else begin
      scan_char_r <= SPACE_CODE;
    end
  end

  // Outputs straight from registers
  assign bus_lines_o          = bus_out_r;
  assign bus_lines_oe_o       = bus_oe_r;
  assign scan_char_o          = scan_char_r;
  assign internal_busy_flag_o = busy_r;
  assign address_pointer_o    = ptr_r;
  assign display_on_o         = disp_on_r;
  assign cursor_on_o          = cur_on_r;
  assign cursor_blink_o       = blink_r;
  assign two_line_o           = two_line_r;
  assign tall_font_o          = tall_r;
  assign bus_width_select_o   = bus8_r;
  assign entry_increment_o    = inc_r;
  assign scroll_on_write_o    = scroll_r;
  assign display_shift_o      = shift_r;

endmodule : clid_decoder

`default_nettype wire

// ### verif/clid_decoder_properties.sv
// Port checks of the instruction decoder, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module clid_decoder_checker
  import clid_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = CYC_LONG,
  parameter int unsigned DATA_CYCLES = CYC_DATA
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       cmd_data_select_i,
  input wire logic       read_not_write_i,
  input wire logic       enable_strobe_i,
  input wire logic [7:0] bus_lines_o,
  input wire logic       bus_lines_oe_o,
  input wire logic [7:0] scan_char_o,
  input wire logic       internal_busy_flag_o,
  input wire logic [6:0] address_pointer_o,
  input wire logic       display_on_o,
  input wire logic       two_line_o,
  input wire logic       bus_width_select_o,
  input wire logic       entry_increment_o,
  input wire logic [6:0] display_shift_o
);
  logic [CNT_W-1:0] busy_cnt_r;

  // Length of the current busy run
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !internal_busy_flag_o)
      busy_cnt_r <= '0;
    else
      busy_cnt_r <= busy_cnt_r + 1'b1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Status read strobe held, then drive enable rises
  sequence status_rd_s;
    (enable_strobe_i && read_not_write_i && !cmd_data_select_i) [*2]
      ##1 $rose(bus_lines_oe_o);
  endsequence

  busy_length_a: assert property ($fell(internal_busy_flag_o) |->
    (busy_cnt_r == CYC_SHORT || busy_cnt_r == LONG_CYCLES ||
     busy_cnt_r == DATA_CYCLES)) else $error("busy run length wrong");
  ptr_on_accept_a: assert property (!$stable(address_pointer_o) |->
    $rose(internal_busy_flag_o)) else $error("pointer moved unaccepted");
  cfg_on_accept_a: assert property (!$stable({display_on_o, two_line_o,
    bus_width_select_o, entry_increment_o}) |-> $rose(internal_busy_flag_o))
    else $error("settings moved unaccepted");
  shift_on_accept_a: assert property (!$stable(display_shift_o) |->
    $rose(internal_busy_flag_o)) else $error("display offset moved");
  status_value_a: assert property (status_rd_s |-> !bus_width_select_o ||
    bus_lines_o[6:0] == address_pointer_o) else $error("status pointer wrong");
  oe_cause_a: assert property ($rose(bus_lines_oe_o) |->
    $past(read_not_write_i, 2) && $past(enable_strobe_i, 2))
    else $error("bus driven without read strobe");
  oe_release_a: assert property ($fell(enable_strobe_i) |->
    ##[1:6] !bus_lines_oe_o) else $error("bus not released");
  blank_off_a: assert property (!display_on_o && !$past(display_on_o) |->
    scan_char_o == SPACE_CODE) else $error("display not blanked");
  nib_low_zero_a: assert property ($rose(bus_lines_oe_o) &&
    !bus_width_select_o |-> bus_lines_o[3:0] == 4'h0)
    else $error("narrow read low lines not zero");
endmodule : clid_decoder_checker

bind clid_decoder clid_decoder_checker #(
  .LONG_CYCLES(LONG_CYCLES), .DATA_CYCLES(DATA_CYCLES)
) clid_decoder_checker_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .cmd_data_select_i(cmd_data_select_i), .read_not_write_i(read_not_write_i),
  .enable_strobe_i(enable_strobe_i), .bus_lines_o(bus_lines_o),
  .bus_lines_oe_o(bus_lines_oe_o), .scan_char_o(scan_char_o),
  .internal_busy_flag_o(internal_busy_flag_o),
  .address_pointer_o(address_pointer_o), .display_on_o(display_on_o),
  .two_line_o(two_line_o), .bus_width_select_o(bus_width_select_o),
  .entry_increment_o(entry_increment_o), .display_shift_o(display_shift_o)
);
`default_nettype wire

// ### verif/clid_host_model.sv
// Host processor model driving the parallel strobe bus
`timescale 1ns/1ps
`default_nettype none
module clid_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  output var  logic       sel_o,
  output var  logic       rw_o,
  output var  logic       e_o,
  output wire logic [7:0] bus_o
);
  logic [7:0] data_r;
  logic       drv_r;
  logic [7:0] float_r;
  logic       nib;

  // Idle levels at time zero
  initial begin
    sel_o = 1'b0;
    rw_o = 1'b1;
    e_o = 1'b0;
    data_r = 8'h00;
    drv_r = 1'b0;
    float_r = 8'h5A;
    nib = 1'b0;
  end

  // Released bus toggles, so a stale value never reads back
  always @(posedge clk_sys_i) float_r <= ~float_r;
  assign bus_o = dev_oe_i ? dev_data_i : (drv_r ? data_r : float_r);

  // One enable cycle: setup, pulse, hold, rest
  task automatic strobe(input logic s, input logic r, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_sys_i);
    sel_o <= s;
    rw_o <= r;
    data_r <= d;
    drv_r <= !r;
    repeat (10) @(posedge clk_sys_i);
    e_o <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    q = bus_o;
    e_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    drv_r <= 1'b0;
    repeat (15) @(posedge clk_sys_i);
  endtask : strobe

  // Whole byte, split into nibbles on the narrow bus
  task automatic xfer(input logic s, input logic r, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nib) begin
      strobe(s, r, {d[7:4], 4'h0}, hi);
      strobe(s, r, {d[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      strobe(s, r, d, q);
    end
  endtask : xfer

  // Poll busy, then keep the half oscillator period gap
  task automatic wait_idle(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, st);
      ok = (st[7] === 1'b0);
    end
    repeat (185) @(posedge clk_sys_i);
  endtask : wait_idle
endmodule : clid_host_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clid_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [6:0] scan_addr = 7'h00;
  wire        sel, rw, en, oe, busy, disp, cur, blink, two, tall, bw, inc, scr;
  wire  [7:0] bus_w, dout, scan;
  wire  [6:0] ptr, shift;
  wire  [7:0] cfg = {disp, cur, blink, two, tall, bw, inc, scr};
  logic [7:0] q;
  logic       ok;
  int         n_fail = 0;
  int         check_count = 0;
  int         cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  clid_decoder #(.LONG_CYCLES(300), .DATA_CYCLES(40)) clid_decoder_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_data_select_i(sel),
    .read_not_write_i(rw), .enable_strobe_i(en), .bus_lines_i(bus_w),
    .bus_lines_o(dout), .bus_lines_oe_o(oe), .scan_addr_i(scan_addr),
    .scan_char_o(scan), .internal_busy_flag_o(busy),
    .address_pointer_o(ptr), .display_on_o(disp), .cursor_on_o(cur),
    .cursor_blink_o(blink), .two_line_o(two), .tall_font_o(tall),
    .bus_width_select_o(bw), .entry_increment_o(inc),
    .scroll_on_write_o(scr), .display_shift_o(shift));

  clid_host_model clid_host_model_i (
    .clk_sys_i(clk_sys_i), .dev_data_i(dout), .dev_oe_i(oe),
    .sel_o(sel), .rw_o(rw), .e_o(en), .bus_o(bus_w));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Write a byte; wait for idle
  task automatic put(input logic s, input logic [7:0] b);
    clid_host_model_i.xfer(s, 1'b0, b, q);
    clid_host_model_i.wait_idle(ok);
    chk({7'h00, ok}, 8'h01, "idle");
  endtask : put

  // Read a byte; data reads also wait for idle
  task automatic get(input logic s, output logic [7:0] r);
    clid_host_model_i.xfer(s, 1'b1, 8'h00, r);
    if (s) begin
      clid_host_model_i.wait_idle(ok);
      chk({7'h00, ok}, 8'h01, "idle");
    end
  endtask : get

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      $display("MISMATCH t=%0t run too long", $time);
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(cfg, 8'h06, "reset cfg");
    chk({1'b0, ptr}, 8'h00, "reset ptr");
    chk(scan, 8'h20, "reset scan");
    done("reset");
    put(1'b0, 8'h3C);
    chk(cfg, 8'h1E, "function set");
    clid_host_model_i.xfer(1'b0, 1'b0, 8'h0F, q);
    get(1'b0, q);
    chk({7'h00, q[7]}, 8'h01, "busy seen");
    clid_host_model_i.xfer(1'b1, 1'b0, 8'h55, q);
    clid_host_model_i.wait_idle(ok);
    chk({1'b0, ptr}, 8'h00, "refused write");
    chk(cfg, 8'hFE, "display control");
    done("busy");
    put(1'b0, 8'h85);
    get(1'b0, q);
    chk(q, 8'h05, "status");
    put(1'b1, 8'h41);
    put(1'b1, 8'h42);
    chk({1'b0, ptr}, 8'h07, "write step");
    put(1'b0, 8'h85);
    get(1'b1, q);
    chk(q, 8'h41, "read data");
    chk({1'b0, ptr}, 8'h06, "read step");
    done("text");
    put(1'b0, 8'h04);
    chk(cfg, 8'hFC, "entry dec");
    put(1'b1, 8'h43);
    chk({1'b0, ptr}, 8'h05, "dec step");
    chk({1'b0, shift}, 8'h00, "no scroll");
    put(1'b0, 8'h41);
    chk({1'b0, ptr}, 8'h01, "glyph addr");
    put(1'b1, 8'h1F);
    chk({1'b0, ptr}, 8'h00, "glyph step");
    put(1'b0, 8'h41);
    get(1'b1, q);
    chk(q, 8'h1F, "glyph read");
    done("entry");
    scan_addr <= 7'h05;
    put(1'b0, 8'h01);
    chk(cfg, 8'hFE, "clear inc");
    chk({1'b0, ptr}, 8'h00, "clear ptr");
    chk(scan, 8'h20, "clear fill");
    put(1'b0, 8'h07);
    chk(cfg, 8'hFF, "entry shift");
    put(1'b1, 8'h48);
    chk({1'b0, shift}, 8'h01, "scroll write");
    get(1'b1, q);
    chk(q, 8'h20, "cleared cell");
    chk({1'b0, shift}, 8'h01, "read no scroll");
    put(1'b0, 8'h18);
    chk({1'b0, shift}, 8'h02, "display left");
    put(1'b0, 8'h14);
    chk({1'b0, ptr}, 8'h03, "cursor right");
    put(1'b0, 8'h05);
    put(1'b1, 8'h49);
    chk({1'b0, shift}, 8'h01, "scroll right");
    done("shift");
    scan_addr <= 7'h00;
    put(1'b0, 8'h02);
    chk({1'b0, ptr}, 8'h00, "home ptr");
    chk({1'b0, shift}, 8'h00, "home shift");
    chk(scan, 8'h48, "home keeps text");
    put(1'b0, 8'h08);
    chk(cfg, 8'h1D, "display off");
    chk(scan, 8'h20, "blanked");
    done("home");
    clid_host_model_i.xfer(1'b0, 1'b0, 8'h28, q);
    clid_host_model_i.nib = 1'b1;
    clid_host_model_i.wait_idle(ok);
    chk(cfg, 8'h11, "narrow bus");
    put(1'b0, 8'hC0);
    get(1'b0, q);
    chk(q, 8'h40, "nibble status");
    chk({1'b0, ptr}, 8'h40, "nibble addr");
    done("nibble");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
